// File: rtl/stie_pkg.sv
// Package with register map, field layouts and timing constants of the transfer interrupt block
package stie_pkg;

    // ****************************************************************
    // Register map (plain port, 4-bit address, 8-bit data)
    // ****************************************************************
    localparam logic [3:0] STIE_ADDR_ACC0 = 4'h0; // Access registers 0..3 at 0x0..0x3
    localparam logic [3:0] STIE_ADDR_SEL0 = 4'h4; // Slot/port select 0..3 at 0x4..0x7
    localparam logic [3:0] STIE_ADDR_CTL1 = 4'h8; // Channel control, pair 1
    localparam logic [3:0] STIE_ADDR_CTL2 = 4'h9; // Channel control, pair 2
    localparam logic [3:0] STIE_ADDR_ACK = 4'hA; // Transfer acknowledge, write only
    localparam logic [3:0] STIE_ADDR_MSK = 4'hB; // Interrupt enable / mask
    localparam logic [3:0] STIE_ADDR_STS = 4'hC; // Sticky status, cleared by read

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] STIE_RST_ACC = 8'hFF;
    localparam logic [7:0] STIE_RST_SEL = 8'h00;
    localparam logic [7:0] STIE_RST_CTL = 8'h00;
    localparam logic [7:0] STIE_RST_MSK = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int STIE_MSK_XFER_LSB = 0; // Bits 3:0 transfer interrupts
    localparam int STIE_MSK_OVF_LSB = 4; // Bits 7:4 overflow interrupts

    // Slot/port select register layout
    typedef struct packed {
        logic port_select_bit; // 0: output on downstream, input from upstream
        logic [2:0] rsvd;
        logic [3:0] slot_select_field;
    } stie_sel_t;

    // Channel control register layout
    typedef struct packed {
        logic [2:0] rsvd;
        logic echo_monitor_enable;
        logic out_en_odd;
        logic in_en_odd;
        logic out_en_even;
        logic in_en_even;
    } stie_ctl_t;

    // ****************************************************************
    // Frame timing
    // ****************************************************************
    localparam int STIE_NUM_REG = 4;
    localparam int STIE_SLOTS = 12;
    localparam int STIE_BITS_PER_SLOT = 8;
    localparam logic [7:0] STIE_FRAME_BITS = 8'h60; // 96 bit clocks per frame
    localparam logic [3:0] STIE_ECHO_SLOT = 4'hB; // Slot 11
    localparam logic [7:0] STIE_DLY_PS0 = 8'h02; // Bit clocks after slot, port bit 0
    localparam logic [7:0] STIE_DLY_PS1 = 8'h01; // Bit clocks after slot, port bit 1
    localparam int STIE_DCL_PER_BCL = 2; // Double-rate clock periods per bit clock

endpackage

// File: rtl/stie_core.sv
// Transfer interrupt, overflow interrupt and echo-slot monitor for four access registers
`timescale 1ns/1ns

// Function
// - Echo monitor enable makes the even register capture slot 11.
// - Echo slot and odd register slot 3 may be watched together.
// - Four transfer and four overflow interrupts, one pair per access register.
// - Transfer fires two bit clocks after slot for port bit 0, one for 1.
// - Event timing counts bit clocks of two double-rate clock periods each.
// - Own overflow only while own transfer enabled and unacknowledged.
// - Own transfer masked: overflow for any other enabled unacknowledged transfer.
// - No transfer enabled means no interrupt at all.
// - Overflow suppressed when all stimulating transfers are acknowledged.
// - Transfer interrupt needs the register input enabled.
// - Overflow interrupt needs the register output enabled.
// - Masked-own overflow fires once per unacknowledged enabled transfer, maybe several.
// - Slot select field picks one of twelve slots, zero to eleven.
// - Port select bit routes output to upstream or downstream line.
module stie_core
    import stie_pkg::*;
(
    input wire logic clk_i, // 10 MHz system clock
    input wire logic rst_n_i, // Asynchronous reset, active low
    input wire logic [3:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    input wire logic double_rate_clock_i, // Frame bus data clock pin
    input wire logic frame_sync_i, // Frame sync pin, high at frame start
    input wire logic upstream_line_i, // Upstream line level
    input wire logic downstream_line_i, // Downstream line level
    output logic upstream_line_o, // Upstream line drive value
    output logic upstream_line_oe_o, // Upstream line driven
    output logic downstream_line_o, // Downstream line drive value
    output logic downstream_line_oe_o, // Downstream line driven
    output logic irq_o // Level interrupt
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic dcl_d3_q;
    // Two stages for every pin, plus a third on the data clock whose output also feeds the edge detect
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            dcl_d3_q <= 1'b0;
        end else begin
            pin_s1_q <= {downstream_line_i, upstream_line_i, frame_sync_i, double_rate_clock_i};
            pin_s2_q <= pin_s1_q;
            dcl_d3_q <= pin_s2_q[0];
        end
    end

    logic dcl_rise;
    logic fsc_s;
    logic up_s;
    logic dn_s;
    assign dcl_rise = pin_s2_q[0] & ~dcl_d3_q;
    assign fsc_s = pin_s2_q[1];
    assign up_s = pin_s2_q[2];
    assign dn_s = pin_s2_q[3];
    // ****************************************************************
    // Bit clock and frame position
    // ****************************************************************
    logic dcl_half_q;
    logic [7:0] bit_cnt_q;
    logic bit_tick;
    logic [7:0] bit_cnt_d;
    // A bit clock is every second rising double-rate clock edge
    assign bit_tick = dcl_rise & dcl_half_q;
    always_comb begin
        if (fsc_s) begin
            bit_cnt_d = 8'h00;
        end else if (bit_cnt_q == STIE_FRAME_BITS - 8'h01) begin
            bit_cnt_d = 8'h00;
        end else begin
            bit_cnt_d = bit_cnt_q + 8'h01;
        end
    end
    // Frame sync resynchronises the position so a glitch costs at most one frame
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dcl_half_q <= 1'b0;
            bit_cnt_q <= 8'h00;
        end else begin
            if (dcl_rise) begin
                dcl_half_q <= ~dcl_half_q;
            end
            if (bit_tick) begin
                bit_cnt_q <= bit_cnt_d;
            end
        end
    end

    logic [3:0] cur_slot;
    logic [2:0] cur_bit;
    assign cur_slot = bit_cnt_q[6:3];
    assign cur_bit = bit_cnt_q[2:0];
    // ****************************************************************
    // Software registers
    // ****************************************************************
    logic [7:0] acc_q [STIE_NUM_REG];
    stie_sel_t sel_q [STIE_NUM_REG];
    stie_ctl_t ctl_q [2];
    logic [7:0] msk_q;
    logic [7:0] sts_q;
    logic [3:0] pend_q;
    logic [7:0] up_sh_q;
    logic [7:0] dn_sh_q;
    logic [7:0] up_byte;
    logic [7:0] dn_byte;
    assign up_byte = {up_sh_q[6:0], up_s};
    assign dn_byte = {dn_sh_q[6:0], dn_s};
    // Serial shifters, one bit per bit clock, most significant bit first
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            up_sh_q <= 8'h00;
            dn_sh_q <= 8'h00;
        end else if (bit_tick) begin
            up_sh_q <= up_byte;
            dn_sh_q <= dn_byte;
        end
    end

    // ****************************************************************
    // Per-register decode
    // ****************************************************************
    logic [3:0] in_en;
    logic [3:0] out_en;
    logic [3:0] cap_hit;
    logic [3:0] xfer_hit;
    logic [3:0] dl_hit;
    logic [3:0] drv_hit;
    logic [7:0] cap_byte [STIE_NUM_REG];
    genvar gi;
    generate
        for (gi = 0; gi < STIE_NUM_REG; gi++) begin : g_reg
            logic [7:0] slot_pos;
            logic [7:0] dly;
            logic [7:0] xfer_pos;
            logic [7:0] dl_pos;
            logic [3:0] cap_slot;
            logic echo;
            logic slot_ok;
            // Even registers of a pair may be redirected to the echo slot
            if (gi % 2 == 0) begin : g_even
                assign echo = ctl_q[gi / 2].echo_monitor_enable;
                assign in_en[gi] = ctl_q[gi / 2].in_en_even;
                assign out_en[gi] = ctl_q[gi / 2].out_en_even;
            end else begin : g_odd
                assign echo = 1'b0;
                assign in_en[gi] = ctl_q[gi / 2].in_en_odd;
                assign out_en[gi] = ctl_q[gi / 2].out_en_odd;
            end
            // Slot values 12..15 have no frame position; the wrapped sums below must not fire
            assign slot_ok = sel_q[gi].slot_select_field < 4'(STIE_SLOTS);
            assign slot_pos = {1'b0, sel_q[gi].slot_select_field, 3'b000};
            assign dly = sel_q[gi].port_select_bit ? STIE_DLY_PS1 : STIE_DLY_PS0;
            // Transfer point: end of slot plus the port dependent delay
            assign xfer_pos = (slot_pos + 8'h07 + dly) % STIE_FRAME_BITS;
            // Acknowledge deadline: the same delay before the slot starts
            assign dl_pos = (slot_pos + STIE_FRAME_BITS - dly) % STIE_FRAME_BITS;
            assign cap_slot = echo ? STIE_ECHO_SLOT : sel_q[gi].slot_select_field;
            // Input comes from the line opposite to the output line
            assign cap_byte[gi] = sel_q[gi].port_select_bit ? dn_byte : up_byte;
            assign cap_hit[gi] = bit_tick & in_en[gi] & (cur_slot == cap_slot) & (cur_bit == 3'h7);
            assign xfer_hit[gi] = bit_tick & slot_ok & (bit_cnt_q == xfer_pos);
            assign dl_hit[gi] = bit_tick & slot_ok & (bit_cnt_q == dl_pos);
            assign drv_hit[gi] = out_en[gi] & (cur_slot == sel_q[gi].slot_select_field);
        end
    endgenerate

    // ****************************************************************
    // Register writes and captures
    // ****************************************************************
    logic acc_wr;
    assign acc_wr = wr_i & (addr_i[3:2] == STIE_ADDR_ACC0[3:2]);
    // Capture wins over a software write in the same cycle; data is newer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < STIE_NUM_REG; i++) begin
                acc_q[i] <= STIE_RST_ACC;
            end
        end else begin
            for (int i = 0; i < STIE_NUM_REG; i++) begin
                if (cap_hit[i]) begin
                    acc_q[i] <= cap_byte[i];
                end else if (acc_wr && addr_i[1:0] == 2'(i)) begin
                    acc_q[i] <= wdata_i;
                end
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < STIE_NUM_REG; i++) begin
                sel_q[i] <= STIE_RST_SEL;
            end
            ctl_q[0] <= STIE_RST_CTL;
            ctl_q[1] <= STIE_RST_CTL;
            msk_q <= STIE_RST_MSK;
        end else if (wr_i) begin
            if (addr_i[3:2] == STIE_ADDR_SEL0[3:2]) begin
                sel_q[addr_i[1:0]] <= wdata_i;
            end
            if (addr_i == STIE_ADDR_CTL1) begin
                ctl_q[0] <= wdata_i;
            end
            if (addr_i == STIE_ADDR_CTL2) begin
                ctl_q[1] <= wdata_i;
            end
            if (addr_i == STIE_ADDR_MSK) begin
                msk_q <= wdata_i;
            end
        end
    end

    // ****************************************************************
    // Transfer and overflow events
    // ****************************************************************
    logic [3:0] xfer_en;
    logic [3:0] ovf_en;
    logic [3:0] xfer_ev;
    logic [3:0] ovf_ev;
    logic [3:0] ack_set;
    assign xfer_en = msk_q[STIE_MSK_XFER_LSB +: 4];
    assign ovf_en = msk_q[STIE_MSK_OVF_LSB +: 4];
    assign ack_set = (wr_i && addr_i == STIE_ADDR_ACK) ? wdata_i[3:0] : 4'h0;
    // Transfer needs its enable and the register input enabled
    assign xfer_ev = xfer_hit & xfer_en & in_en;
    // Each unacknowledged stimulating transfer at its deadline is one overflow event
    always_comb begin
        ovf_ev = 4'h0;
        for (int j = 0; j < STIE_NUM_REG; j++) begin
            for (int i = 0; i < STIE_NUM_REG; i++) begin
                if (dl_hit[i] && pend_q[i] && xfer_en[i] && (i == j || !xfer_en[j])) begin
                    ovf_ev[j] = ovf_en[j] & out_en[j];
                end
            end
        end
    end
    // Pending transfers; a new transfer in the acknowledge cycle stays pending
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_q <= 4'h0;
        end else begin
            pend_q <= (pend_q & ~ack_set) | xfer_ev;
        end
    end

    // ****************************************************************
    // Status, interrupt and read port
    // ****************************************************************
    logic sts_rd;
    logic [7:0] sts_d;
    assign sts_rd = rd_i & (addr_i == STIE_ADDR_STS);
    // Read clears, but events in the same cycle survive the clear
    assign sts_d = (sts_rd ? 8'h00 : sts_q) | {ovf_ev, xfer_ev};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sts_q <= 8'h00;
            irq_o <= 1'b0;
        end else begin
            sts_q <= sts_d;
            irq_o <= |(sts_d & msk_q);
        end
    end
    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                4'h0, 4'h1, 4'h2, 4'h3: rdata_o <= acc_q[addr_i[1:0]];
                4'h4, 4'h5, 4'h6, 4'h7: rdata_o <= sel_q[addr_i[1:0]];
                STIE_ADDR_CTL1: rdata_o <= ctl_q[0];
                STIE_ADDR_CTL2: rdata_o <= ctl_q[1];
                STIE_ADDR_MSK: rdata_o <= msk_q;
                STIE_ADDR_STS: rdata_o <= sts_q;
                default: rdata_o <= 8'h00; // Acknowledge and unmapped read zero
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ****************************************************************
    // Line drivers
    // ****************************************************************
    logic up_drv;
    logic dn_drv;
    logic up_val;
    logic dn_val;
    // Only one register may own a slot on a line; the lowest index wins on a clash
    always_comb begin
        up_drv = 1'b0;
        dn_drv = 1'b0;
        up_val = 1'b0;
        dn_val = 1'b0;
        for (int i = STIE_NUM_REG - 1; i >= 0; i--) begin
            if (drv_hit[i] && sel_q[i].port_select_bit) begin
                up_drv = 1'b1;
                up_val = acc_q[i][3'h7 - cur_bit];
            end
            if (drv_hit[i] && !sel_q[i].port_select_bit) begin
                dn_drv = 1'b1;
                dn_val = acc_q[i][3'h7 - cur_bit];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            upstream_line_o <= 1'b0;
            upstream_line_oe_o <= 1'b0;
            downstream_line_o <= 1'b0;
            downstream_line_oe_o <= 1'b0;
        end else begin
            upstream_line_o <= up_val;
            upstream_line_oe_o <= up_drv;
            downstream_line_o <= dn_val;
            downstream_line_oe_o <= dn_drv;
        end
    end

endmodule // stie_core

// File: tb/stie_core_asserts.sv
// Port-level assertions for the transfer interrupt core
`timescale 1ns/1ns
module stie_core_asserts
    import stie_pkg::*;
(
    input wire logic clk_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire logic [3:0] addr_i, // Address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [7:0] rdata_o, // Read data
    input wire logic double_rate_clock_i, // Data clock
    input wire logic frame_sync_i, // Frame sync
    input wire logic upstream_line_i, // Upstream in
    input wire logic downstream_line_i, // Downstream in
    input wire logic upstream_line_o, // Upstream out
    input wire logic upstream_line_oe_o, // Upstream enable
    input wire logic downstream_line_o, // Downstream out
    input wire logic downstream_line_oe_o, // Downstream enable
    input wire logic irq_o // Interrupt
);
    // ****************************************************************
    // Helper state
    // ****************************************************************
    // Shadow of the enable register, so no peeking inside is needed
    logic [7:0] msk_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msk_q <= STIE_RST_MSK;
        end else if (wr_i && addr_i == STIE_ADDR_MSK) begin
            msk_q <= wdata_i;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_reset_quiet: assert property ($rose(rst_n_i) |-> irq_o == 1'b0 && rdata_o == 8'h00)
        else $error("outputs not quiet after reset");
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data outside read cycle");
    chk_unmapped_zero: assert property (rd_i && addr_i > STIE_ADDR_STS |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_mask_readback: assert property (wr_i && addr_i == STIE_ADDR_MSK ##1 rd_i && addr_i == STIE_ADDR_MSK
        |=> rdata_o == $past(wdata_i, 2)) else $error("enable register readback wrong");
    chk_select_readback: assert property (wr_i && addr_i[3:2] == 2'h1 ##1 rd_i && addr_i == $past(addr_i)
        |=> {rdata_o[7], rdata_o[3:0]} == {$past(wdata_i[7], 2), $past(wdata_i[3:0], 2)})
        else $error("select register readback wrong");
    chk_irq_needs_xfer: assert property (msk_q[3:0] == 4'h0 && $past(msk_q[3:0]) == 4'h0
        && $past(msk_q[3:0], 2) == 4'h0 |-> !$rose(irq_o)) else $error("interrupt without transfer enable");
    chk_mask_clear_irq: assert property (wr_i && addr_i == STIE_ADDR_MSK && wdata_i == 8'h00 |-> ##2 !irq_o)
        else $error("interrupt survives full mask");
    chk_status_nonzero: assert property (rd_i && addr_i == STIE_ADDR_STS && irq_o
        && !$past(rd_i && addr_i == STIE_ADDR_STS) |=> rdata_o != 8'h00) else $error("interrupt with empty status");
endmodule // stie_core_asserts

bind stie_core stie_core_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .double_rate_clock_i(double_rate_clock_i),
    .frame_sync_i(frame_sync_i), .upstream_line_i(upstream_line_i), .downstream_line_i(downstream_line_i),
    .upstream_line_o(upstream_line_o), .upstream_line_oe_o(upstream_line_oe_o),
    .downstream_line_o(downstream_line_o), .downstream_line_oe_o(downstream_line_oe_o), .irq_o(irq_o));

// File: tb/stie_frame_model.sv
// Frame bus model: data clock, frame sync and per-slot line patterns
`timescale 1ns/1ns
module stie_frame_model (
    input wire logic clk_i, // System clock
    input wire logic rst_n_i, // Reset, active low
    output logic dcl_o, // Double-rate data clock
    output logic sync_o, // Frame sync
    output logic up_o, // Upstream line
    output logic dn_o // Downstream line
);
    logic [1:0] ph_q;
    logic tick_q;
    logic [6:0] pos_q;
    logic [6:0] nxt;
    logic [7:0] up_byte;
    logic [7:0] dn_byte;
    // Slot bytes carry their slot number so a capture shows where it came from
    assign nxt = (pos_q == 7'h5F) ? 7'h00 : pos_q + 7'h01;
    assign up_byte = {4'hA, pos_q[6:3]};
    assign dn_byte = {4'h5, pos_q[6:3]};
    // Data clock of four system clocks; sync is raised half a bit early so it is stable at the tick
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_q <= 2'h0;
            dcl_o <= 1'b0;
            tick_q <= 1'b0;
            pos_q <= 7'h5F;
            sync_o <= 1'b0;
            up_o <= 1'b0;
            dn_o <= 1'b0;
        end else begin
            ph_q <= ph_q + 2'h1;
            dcl_o <= ~ph_q[1];
            if (ph_q == 2'h0) begin
                tick_q <= ~tick_q;
                if (tick_q) begin
                    pos_q <= nxt;
                end else begin
                    // Bit of the current position, settled half a bit before the tick that samples it
                    sync_o <= (pos_q == 7'h5F);
                    up_o <= up_byte[~pos_q[2:0]];
                    dn_o <= dn_byte[~pos_q[2:0]];
                end
            end
        end
    end
endmodule // stie_frame_model

// File: tb/stie_core_bench.sv
// Self-checking bench for the transfer interrupt core
`timescale 1ns/1ns
module stie_core_bench
    import stie_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic irq_o, up_o, up_oe, dn_o, dn_oe, double_rate_clock, fsync, up_m, dn_m, up_w, dn_w;
    int fail_count = 0;
    int n_checks = 0;
    // Wire level: the core wins while it drives, else the bus model
    assign up_w = up_oe ? up_o : up_m;
    assign dn_w = dn_oe ? dn_o : dn_m;
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    stie_core DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .double_rate_clock_i(double_rate_clock), .frame_sync_i(fsync),
        .upstream_line_i(up_w), .downstream_line_i(dn_w), .upstream_line_o(up_o), .upstream_line_oe_o(up_oe),
        .downstream_line_o(dn_o), .downstream_line_oe_o(dn_oe), .irq_o(irq_o));
    stie_frame_model u_frm (.clk_i(clk_i), .rst_n_i(rst_n_i), .dcl_o(double_rate_clock), .sync_o(fsync), .up_o(up_m),
        .dn_o(dn_m));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Every task starts just after an edge and ends 1 ns after one, so strobes never collide
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic wait_for(input logic use_sync, input logic lvl);
        int i;
        for (i = 0; i < 2000 && (use_sync ? fsync : irq_o) !== lvl; i++) cyc(1);
        if (i == 2000) begin
            fail_count++;
            test_done();
        end
    endtask
    // Cycles from frame start to the transfer interrupt, 0 when none comes
    task automatic measure(input logic [7:0] sel, output logic [31:0] t);
        logic [7:0] d;
        int i;
        wr(STIE_ADDR_SEL0, sel);
        wait_for(1'b1, 1'b0);
        wait_for(1'b1, 1'b1);
        rd(STIE_ADDR_STS, d);
        cyc(2);
        for (i = 0; i < 1000 && irq_o !== 1'b1; i++) cyc(1);
        t = (i < 1000) ? 32'(i) : 32'h0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs;
        logic [7:0] d;
        for (int a = 0; a < 14; a++) begin
            rd(4'(a), d);
            check("reg_reset", d, (a < 4) ? 32'hFF : 32'h0);
        end
        $display("test regs done");
    endtask
    task automatic t_timing;
        logic [7:0] d;
        logic [31:0] ta, tb, tc, td;
        wr(STIE_ADDR_CTL1, 8'h01);
        wr(STIE_ADDR_MSK, 8'h01);
        rd(STIE_ADDR_MSK, d);
        measure(8'h02, ta);
        measure(8'h82, tb);
        measure(8'h03, tc);
        measure(8'h0C, td);
        check("port_lead", ta - tb, 32'h8);
        check("slot_step", tc - ta, 32'h40);
        check("slot_12", td, 32'h0);
        $display("test timing done");
    endtask
    // Control, enables, expected status over one frame with nothing acknowledged
    task automatic t_ovf;
        logic [7:0] d;
        logic [7:0] tbl [7][3] = '{'{8'h0B, 8'h01, 8'h01}, '{8'h0B, 8'h10, 8'h00}, '{8'h0B, 8'h21, 8'h21},
            '{8'h0B, 8'h31, 8'h31}, '{8'h03, 8'h21, 8'h01}, '{8'h0F, 8'h33, 8'h33}, '{8'h02, 8'h01, 8'h00}};
        wr(STIE_ADDR_SEL0, 8'h02);
        wr(STIE_ADDR_SEL0 + 4'h1, 8'h03);
        for (int k = 0; k < 7; k++) begin
            wr(STIE_ADDR_CTL1, tbl[k][0]);
            wr(STIE_ADDR_MSK, tbl[k][1]);
            wr(STIE_ADDR_ACK, 8'h0F);
            cyc(1600);
            rd(STIE_ADDR_STS, d);
            cyc(780);
            rd(STIE_ADDR_STS, d);
            check("ovf_status", d, tbl[k][2]);
        end
        $display("test overflow done");
    endtask
    task automatic t_ack;
        logic [7:0] d;
        wr(STIE_ADDR_CTL1, 8'h0B);
        wr(STIE_ADDR_MSK, 8'h31);
        wait_for(1'b1, 1'b0);
        wait_for(1'b1, 1'b1);
        wr(STIE_ADDR_ACK, 8'h0F);
        rd(STIE_ADDR_STS, d);
        wait_for(1'b0, 1'b1);
        // Slot 3 belongs to the odd register, which drives the downstream line
        check("line_oe", {up_oe, dn_oe}, 32'h1);
        rd(STIE_ADDR_STS, d);
        check("xfer_only", d, 8'h01);
        // Access data is touched only between the transfer and the overflow interrupt
        rd(STIE_ADDR_ACC0, d);
        check("acc_in_window", d, 8'hA2);
        wr(STIE_ADDR_ACK, 8'h01);
        cyc(720);
        rd(STIE_ADDR_STS, d);
        check("acked_quiet", d, 8'h00);
        wr(STIE_ADDR_MSK, 8'h00);
        $display("test ack done");
    endtask
    task automatic t_echo;
        logic [7:0] d;
        wr(STIE_ADDR_CTL1, 8'h15);
        for (int k = 0; k < 2; k++) begin
            wr(STIE_ADDR_SEL0, k ? 8'h88 : 8'h08);
            rd(STIE_ADDR_SEL0, d);
            check("echo_select", d, k ? 8'h88 : 8'h08);
            wr(STIE_ADDR_SEL0 + 4'h1, k ? 8'h83 : 8'h03);
            cyc(1600);
            wait_for(1'b1, 1'b0);
            wait_for(1'b1, 1'b1);
            rd(STIE_ADDR_ACC0, d);
            check("echo_even", d, {k ? 4'h5 : 4'hA, 4'hB});
            rd(STIE_ADDR_ACC0 + 4'h1, d);
            check("odd_slot3", d, {k ? 4'h5 : 4'hA, 4'h3});
        end
        $display("test echo done");
    endtask
    task automatic t_reset;
        logic [7:0] d;
        rst_n_i <= 1'b0;
        cyc(8);
        rst_n_i <= 1'b1;
        rd(STIE_ADDR_ACC0, d);
        check("acc_after_reset", d, STIE_RST_ACC);
        $display("test reset done");
    endtask

    // Main sequence
    initial begin
        cyc(8);
        rst_n_i <= 1'b1;
        t_regs();
        t_timing();
        t_ovf();
        t_ack();
        t_echo();
        t_reset();
        test_done();
    end
endmodule // stie_core_bench
